//--- lpd_pkg.sv
// constants and types shared by the panel drive timing block
package lpd_pkg;
	localparam int          DATA_W       = 4;
	localparam int          BUF_DEPTH    = 2;
	localparam int          NIB_W        = 5;
	localparam int          LINE_W       = 3;
	localparam int          RATIO_W      = 5;
	localparam int          MOD_W        = 8;
	localparam int          LINE_NIBBLES = 32;
	localparam logic [4:0]  NIB_LAST     = 5'h1F;
	localparam logic [3:0]  CHAIN_LAST   = 4'hF;
	localparam logic [2:0]  LINE_LAST    = 3'h7;
	localparam logic [2:0]  LINE_FIRST   = 3'h0;
	localparam logic [1:0]  STRAP_4      = 2'h0;
	localparam logic [1:0]  STRAP_8      = 2'h1;
	localparam logic [1:0]  STRAP_16     = 2'h2;
	localparam logic [4:0]  RATIO_4      = 5'h04;
	localparam logic [4:0]  RATIO_8      = 5'h08;
	localparam logic [4:0]  RATIO_16     = 5'h10;
	localparam logic [4:0]  PHASE_ZERO   = 5'h00;
	localparam logic [7:0]  MOD_FRAME    = 8'h00;

	typedef enum logic [1:0] {
		ST_OFF   = 2'h0,
		ST_GAP   = 2'h1,
		ST_SHIFT = 2'h3,
		ST_LATCH = 2'h2
	} lpd_state_t;
endpackage : lpd_pkg

//--- lpd_buf2.sv
// two-entry valid/ready buffer for column pixel nibbles
`timescale 1ns/1ps
module lpd_buf2 #(
	parameter int WIDTH = lpd_pkg::DATA_W,
	parameter int DEPTH = lpd_pkg::BUF_DEPTH
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic             push;
	logic             pop;

	assign o_ready = (count != CW'(DEPTH));
	assign o_valid = (count != '0);
	assign o_data  = mem[rd_ptr];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
			end
			if (push && !pop) begin
				count <= CW'(count + 1'b1);
			end else if (pop && !push) begin
				count <= CW'(count - 1'b1);
			end
		end
	end
endmodule : lpd_buf2

//--- lpd_timing.sv
// matrix panel drive timing: column shift, line latch, row scan, bias, power-down
// Functional notes
// - column pixel data leaves as a 4-bit parallel bus
// - column data is valid at every falling edge of the column shift clock
// - column shift clock idles low from line latch until next line starts
// - enable chain clock falls once per 16 column nibbles to advance the cascade
// - exactly one line latch pulse per line, falling edge active
// - whole line is shifted in before the line latch pulse
// - bias toggle period set by the configured lines-per-toggle value
// - frame pulse stays stable at every falling edge of the row shift clock
// - frame pulse is high only during the last line of the frame and the first cycle of the next line
// - one row shift clock per line walks the frame pulse down the rows
// - power-down output low from reset until drive becomes active
// - power-down output high while drive outputs are active
// - power save request drops power-down output at the next frame end
// - two-bit strap picks shift period 4, 8 or 16 clocks; fourth code reserved
`timescale 1ns/1ps
module lpd_timing (
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_rst_n,
	input  wire logic [1:0]                  i_shift_ratio_strap,
	input  wire logic                        i_display_on,
	input  wire logic                        i_power_save,
	input  wire logic [lpd_pkg::MOD_W-1:0]   i_bias_period,
	input  wire logic [lpd_pkg::DATA_W-1:0]  i_pix_data,
	input  wire logic                        i_pix_valid,
	output logic                             o_pix_ready,
	output logic [lpd_pkg::DATA_W-1:0]       o_column_data,
	output logic                             o_column_shift_clock,
	output logic                             o_column_enable_chain_clock,
	output logic                             o_line_latch_pulse,
	output logic                             o_backplane_bias_toggle,
	output logic                             o_row_shift_clock,
	output logic                             o_frame_pulse,
	output logic                             o_display_power_down
);
	lpd_pkg::lpd_state_t               state;
	logic [lpd_pkg::RATIO_W-1:0]       ratio;
	logic [lpd_pkg::RATIO_W-1:0]       phase;
	logic [lpd_pkg::NIB_W-1:0]         nib_cnt;
	logic [lpd_pkg::LINE_W-1:0]        line_cnt;
	logic [lpd_pkg::MOD_W-1:0]         bias_cnt;
	logic [1:0]                        strap_s1;
	logic [1:0]                        strap_s2;
	logic [1:0]                        strap_s3;
	logic                              save_pend;
	logic [lpd_pkg::DATA_W-1:0]        buf_data;
	logic                              buf_valid;
	logic                              take;
	logic                              half;
	logic                              last_phase;
	logic                              line_end;
	logic                              frame_end;

	// pixel stream buffer; drained only at a shift-clock rising edge
	lpd_buf2 #(
		.WIDTH (lpd_pkg::DATA_W),
		.DEPTH (lpd_pkg::BUF_DEPTH)
	) lpd_buf2_inst (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_data    (i_pix_data),
		.i_valid   (i_pix_valid),
		.o_ready   (o_pix_ready),
		.o_data    (buf_data),
		.o_valid   (buf_valid),
		.i_ready   (take)
	);

	assign take       = (state == lpd_pkg::ST_SHIFT) && (phase == lpd_pkg::PHASE_ZERO)
	                    && buf_valid;
	assign half       = (phase == (ratio >> 1));
	assign last_phase = (phase == lpd_pkg::RATIO_W'(ratio - 1'b1));
	assign line_end   = (state == lpd_pkg::ST_LATCH) && last_phase;
	assign frame_end  = line_end && (line_cnt == lpd_pkg::LINE_LAST);

	// strap sync: a change counts once the second and third stages agree
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			strap_s1 <= lpd_pkg::STRAP_4;
			strap_s2 <= lpd_pkg::STRAP_4;
			strap_s3 <= lpd_pkg::STRAP_4;
		end else begin
			strap_s1 <= i_shift_ratio_strap;
			strap_s2 <= strap_s1;
			strap_s3 <= strap_s2;
		end
	end

	// ratio only moves between lines so a shift period is never cut short
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ratio <= lpd_pkg::RATIO_4;
		end else if ((strap_s2 == strap_s3) && ((state == lpd_pkg::ST_OFF)
		             || (state == lpd_pkg::ST_GAP && phase == lpd_pkg::PHASE_ZERO))) begin
			if (strap_s3 == lpd_pkg::STRAP_4) begin
				ratio <= lpd_pkg::RATIO_4;
			end else if (strap_s3 == lpd_pkg::STRAP_8) begin
				ratio <= lpd_pkg::RATIO_8;
			end else if (strap_s3 == lpd_pkg::STRAP_16) begin
				ratio <= lpd_pkg::RATIO_16;
			end
		end
	end

	// sequencing state and phase within a shift period
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state <= lpd_pkg::ST_OFF;
			phase <= lpd_pkg::PHASE_ZERO;
		end else begin
			case (state)
				lpd_pkg::ST_OFF: begin
					phase <= lpd_pkg::PHASE_ZERO;
					if (i_display_on) begin
						state <= lpd_pkg::ST_GAP;
					end
				end
				lpd_pkg::ST_GAP: begin
					phase <= last_phase ? lpd_pkg::PHASE_ZERO
					                    : lpd_pkg::RATIO_W'(phase + 1'b1);
					if (last_phase) begin
						state <= lpd_pkg::ST_SHIFT;
					end
				end
				lpd_pkg::ST_SHIFT: begin
					// hold at phase zero while the buffer is empty
					if (phase != lpd_pkg::PHASE_ZERO || take) begin
						phase <= last_phase ? lpd_pkg::PHASE_ZERO
						                    : lpd_pkg::RATIO_W'(phase + 1'b1);
					end
					if (last_phase && nib_cnt == lpd_pkg::NIB_LAST) begin
						state <= lpd_pkg::ST_LATCH;
					end
				end
				lpd_pkg::ST_LATCH: begin
					phase <= last_phase ? lpd_pkg::PHASE_ZERO
					                    : lpd_pkg::RATIO_W'(phase + 1'b1);
					if (frame_end && save_pend) begin
						state <= lpd_pkg::ST_OFF;
					end else if (last_phase) begin
						state <= lpd_pkg::ST_GAP;
					end
				end
				default: begin
					state <= lpd_pkg::ST_OFF;
				end
			endcase
		end
	end

	// nibble position within the line
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			nib_cnt <= '0;
		end else if (state != lpd_pkg::ST_SHIFT) begin
			nib_cnt <= '0;
		end else if (last_phase) begin
			nib_cnt <= lpd_pkg::NIB_W'(nib_cnt + 1'b1);
		end
	end

	// column data, shift clock and enable chain clock
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_column_data               <= '0;
			o_column_shift_clock        <= 1'b0;
			o_column_enable_chain_clock <= 1'b0;
		end else if (state != lpd_pkg::ST_SHIFT) begin
			o_column_shift_clock        <= 1'b0;
			o_column_enable_chain_clock <= 1'b0;
		end else if (take) begin
			o_column_data               <= buf_data;
			o_column_shift_clock        <= 1'b1;
			o_column_enable_chain_clock <= (nib_cnt[3:0] == lpd_pkg::CHAIN_LAST);
		end else if (half) begin
			o_column_shift_clock        <= 1'b0;
			o_column_enable_chain_clock <= 1'b0;
		end
	end

	// line latch and row shift clock: one pulse per line
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_line_latch_pulse <= 1'b0;
			o_row_shift_clock  <= 1'b0;
		end else if (state == lpd_pkg::ST_SHIFT && last_phase
		             && nib_cnt == lpd_pkg::NIB_LAST) begin
			o_line_latch_pulse <= 1'b1;
			o_row_shift_clock  <= 1'b1;
		end else if (line_end) begin
			o_line_latch_pulse <= 1'b0;
			o_row_shift_clock  <= 1'b0;
		end
	end

	// line count and frame pulse; frame pulse only moves at line start
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			line_cnt      <= lpd_pkg::LINE_FIRST;
			o_frame_pulse <= 1'b0;
		end else if (state == lpd_pkg::ST_OFF) begin
			line_cnt      <= lpd_pkg::LINE_FIRST;
			o_frame_pulse <= 1'b0;
		end else if (line_end) begin
			line_cnt <= lpd_pkg::LINE_W'(line_cnt + 1'b1);
		end else if (state == lpd_pkg::ST_GAP
		             && (last_phase || line_cnt != lpd_pkg::LINE_LAST)) begin
			// falls one cycle after the row clock so it holds at that edge
			o_frame_pulse <= (line_cnt == lpd_pkg::LINE_LAST);
		end
	end

	// bias toggle: every N lines, or once a frame when N is zero
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_backplane_bias_toggle <= 1'b0;
			bias_cnt                <= '0;
		end else if (line_end) begin
			if (i_bias_period == lpd_pkg::MOD_FRAME) begin
				bias_cnt <= '0;
				if (frame_end) begin
					o_backplane_bias_toggle <= !o_backplane_bias_toggle;
				end
			end else if (lpd_pkg::MOD_W'(bias_cnt + 1'b1) >= i_bias_period) begin
				bias_cnt                <= '0;
				o_backplane_bias_toggle <= !o_backplane_bias_toggle;
			end else begin
				bias_cnt <= lpd_pkg::MOD_W'(bias_cnt + 1'b1);
			end
		end
	end

	// power save request and power-down output
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			save_pend            <= 1'b0;
			o_display_power_down <= 1'b0;
		end else begin
			if (i_power_save && state != lpd_pkg::ST_OFF) begin
				save_pend <= 1'b1;
			end else if (frame_end || state == lpd_pkg::ST_OFF) begin
				save_pend <= 1'b0;
			end
			if (state == lpd_pkg::ST_OFF) begin
				o_display_power_down <= i_display_on;
			end else if (frame_end && save_pend) begin
				o_display_power_down <= 1'b0;
			end
		end
	end

	// helper for checking: column shift falls since the last latch
	logic [lpd_pkg::NIB_W:0] fall_cnt;
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n || line_end) begin
			fall_cnt <= '0;
		end else if (state == lpd_pkg::ST_SHIFT && half && o_column_shift_clock) begin
			fall_cnt <= (lpd_pkg::NIB_W + 1)'(fall_cnt + 1'b1);
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	a_data_at_fall: assert property (
		$fell(o_column_shift_clock) |-> $stable(o_column_data))
		else $error("column data moved at shift clock fall");
	a_data_on_rise: assert property (
		$changed(o_column_data) |-> $rose(o_column_shift_clock))
		else $error("column data changed off the shift clock rise");
	a_shift_idle_latch: assert property (
		(state == lpd_pkg::ST_LATCH || state == lpd_pkg::ST_GAP) |-> !o_column_shift_clock)
		else $error("shift clock running outside the line");
	a_latch_full_line: assert property (
		$rose(o_line_latch_pulse) |-> fall_cnt == (lpd_pkg::NIB_W + 1)'(lpd_pkg::LINE_NIBBLES))
		else $error("line latch before the full line was shifted");
	a_latch_row_pair: assert property (
		(o_line_latch_pulse && o_row_shift_clock) == (state == lpd_pkg::ST_LATCH))
		else $error("row shift clock not paired with line latch");
	a_frame_last_line: assert property (
		(o_frame_pulse && line_cnt != lpd_pkg::LINE_LAST)
		|-> $past(line_end) && $past(line_cnt) == lpd_pkg::LINE_LAST)
		else $error("frame pulse outside the last line");
	a_frame_row_stable: assert property (
		$fell(o_row_shift_clock) |-> $stable(o_frame_pulse))
		else $error("frame pulse moved at row shift clock fall");
	a_pd_off_low: assert property (
		(state == lpd_pkg::ST_OFF && $past(state) == lpd_pkg::ST_OFF) |-> !o_display_power_down)
		else $error("power-down high while drive is off");
	a_pd_drive_high: assert property (
		(o_column_shift_clock || o_line_latch_pulse) |-> o_display_power_down)
		else $error("drive outputs active with power-down low");
	a_bias_line_edge: assert property (
		$changed(o_backplane_bias_toggle) |-> state != lpd_pkg::ST_SHIFT && $fell(o_line_latch_pulse))
		else $error("bias toggled mid-line");

	c_line_done: cover property ($fell(o_line_latch_pulse));
	c_frame_done: cover property ($fell(o_frame_pulse));
	c_stall: cover property (state == lpd_pkg::ST_SHIFT && !buf_valid ##1 take);
	c_power_save: cover property ($fell(o_display_power_down));
endmodule : lpd_timing

//--- lpd_panel_model.sv
// column and row driver chips as seen from the drive outputs
`timescale 1ns/1ps
module lpd_panel_model (
	input  wire logic                       i_clk_sys,
	input  wire logic [lpd_pkg::DATA_W-1:0] i_column_data,
	input  wire logic                       i_column_shift_clock,
	input  wire logic                       i_column_enable_chain_clock,
	input  wire logic                       i_line_latch_pulse,
	input  wire logic                       i_backplane_bias_toggle,
	input  wire logic                       i_row_shift_clock,
	input  wire logic                       i_frame_pulse,
	input  wire logic                       i_display_power_down
);
	logic [lpd_pkg::DATA_W-1:0] got [0:4095];
	logic [7:0]                 rows        = 8'h00;
	logic [4:0]                 prev        = 5'h00;
	logic [4:0]                 now;
	int                         nib_total   = 0;
	int                         line_nibs   = 0;
	int                         latch_cnt   = 0;
	int                         bad_lines   = 0;
	int                         chain_falls = 0;
	int                         frame_hits  = 0;
	int                         bias_flips  = 0;
	int                         bad_bias    = 0;
	int                         bad_idle    = 0;
	int                         per         = 0;
	int                         since       = 0;

	assign now = {i_column_shift_clock, i_column_enable_chain_clock, i_line_latch_pulse,
		i_row_shift_clock, i_backplane_bias_toggle};

	always @(posedge i_clk_sys) begin
		since++;
		if (now[4] && !prev[4]) begin
			per = since;
			since = 0;
			if (!i_display_power_down || i_line_latch_pulse) bad_idle++;
		end
		if (!now[4] && prev[4]) begin
			if (nib_total < 4096) got[nib_total] = i_column_data;
			nib_total++;
			line_nibs++;
		end
		if (!now[3] && prev[3]) chain_falls++;
		if (!now[2] && prev[2]) begin
			latch_cnt++;
			if (line_nibs != 32) bad_lines++;
			line_nibs = 0;
		end
		if (!now[1] && prev[1]) begin
			rows = {rows[6:0], i_frame_pulse};
			if (i_frame_pulse) frame_hits++;
		end
		if (now[0] != prev[0]) begin
			bias_flips++;
			if (line_nibs != 0 && line_nibs != 32) bad_bias++;
		end
		prev = now;
	end
endmodule : lpd_panel_model

//--- lpd_timing_bench.sv
// self-checking bench for the panel drive timing block
`timescale 1ns/1ps
module lpd_timing_bench;
	logic       clk_sys   = 1'b0;
	logic       rst_n     = 1'b0;
	logic [1:0] strap     = 2'h0;
	logic       disp_on   = 1'b0;
	logic       pwr_save  = 1'b0;
	logic [7:0] bias_per  = 8'h02;
	logic [3:0] pix_data  = 4'h0;
	logic       pix_valid = 1'b0;
	logic       pix_ready;
	logic [3:0] col_data;
	logic       sclk;
	logic       chain;
	logic       latch;
	logic       bias;
	logic       row;
	logic       frame;
	logic       pd;
	logic       feed_en   = 1'b0;
	int         idx       = 0;
	int         cyc       = 0;
	int         error_cnt = 0;
	int         n_checks  = 0;

	always #25 clk_sys = ~clk_sys;

	lpd_timing lpd_timing_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
		.i_shift_ratio_strap(strap), .i_display_on(disp_on), .i_power_save(pwr_save),
		.i_bias_period(bias_per), .i_pix_data(pix_data), .i_pix_valid(pix_valid),
		.o_pix_ready(pix_ready), .o_column_data(col_data), .o_column_shift_clock(sclk),
		.o_column_enable_chain_clock(chain), .o_line_latch_pulse(latch),
		.o_backplane_bias_toggle(bias), .o_row_shift_clock(row), .o_frame_pulse(frame),
		.o_display_power_down(pd));

	lpd_panel_model lpd_panel_model_inst (.i_clk_sys(clk_sys), .i_column_data(col_data),
		.i_column_shift_clock(sclk), .i_column_enable_chain_clock(chain),
		.i_line_latch_pulse(latch), .i_backplane_bias_toggle(bias), .i_row_shift_clock(row),
		.i_frame_pulse(frame), .i_display_power_down(pd));

	function automatic logic [3:0] pat(input int k);
		return 4'(k) ^ 4'(k >> 4) ^ 4'(k >> 8);
	endfunction : pat

	// source stalls one cycle every ninth word
	always @(posedge clk_sys) begin
		if (pix_valid && pix_ready) begin
			idx <= idx + 1;
			pix_data <= pat(idx + 1);
			pix_valid <= feed_en && ((idx + 1) % 9 != 4);
		end else begin
			pix_valid <= feed_en;
		end
	end

	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic pulse(input bit save);
		@(posedge clk_sys);
		if (save) begin
			pwr_save <= 1'b1;
		end else begin
			disp_on <= 1'b1;
		end
		@(posedge clk_sys);
		pwr_save <= 1'b0;
		disp_on  <= 1'b0;
		@(posedge clk_sys);
		#1;
	endtask : pulse

	task automatic wait_lat(input int target, input int lim);
		int n;
		n = 0;
		while (lpd_panel_model_inst.latch_cnt < target && n < lim) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(16'(lpd_panel_model_inst.latch_cnt), 16'(target));
	endtask : wait_lat

	task automatic t_idle;
		feed_en <= 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		chk(16'(pd), 16'h0000);
		chk(16'(pix_ready), 16'h0000);
		chk(16'(idx), 16'h0002);
		chk(16'(lpd_panel_model_inst.nib_total), 16'h0000);
	endtask : t_idle

	task automatic t_frames;
		pulse(1'b0);
		chk(16'(pd), 16'h0001);
		wait_lat(16, 4000);
		chk(16'(lpd_panel_model_inst.nib_total), 16'h0200);
		chk(16'(lpd_panel_model_inst.bad_lines), 16'h0000);
		chk(16'(lpd_panel_model_inst.chain_falls), 16'h0020);
		chk(16'(lpd_panel_model_inst.frame_hits), 16'h0002);
		chk(16'(lpd_panel_model_inst.rows), 16'h0001);
		chk(16'(lpd_panel_model_inst.bias_flips), 16'h0008);
		chk(16'(lpd_panel_model_inst.bad_bias), 16'h0000);
	endtask : t_frames

	task automatic t_save(input int r);
		int n;
		int held;
		n = 0;
		pulse(1'b1);
		while (pd !== 1'b0 && n < 2 * 272 * r) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(16'(pd), 16'h0000);
		held = lpd_panel_model_inst.nib_total;
		repeat (200) @(posedge clk_sys);
		#1;
		chk(16'(lpd_panel_model_inst.nib_total), 16'(held));
	endtask : t_save

	task automatic t_ratio(input logic [1:0] s, input int r, input logic [7:0] bp, input int f);
		int base;
		base = lpd_panel_model_inst.bias_flips;
		@(posedge clk_sys);
		strap    <= s;
		bias_per <= bp;
		repeat (5) @(posedge clk_sys);
		pulse(1'b0);
		wait_lat(lpd_panel_model_inst.latch_cnt + 1, 40 * r);
		chk(16'(lpd_panel_model_inst.per), 16'(r));
		t_save(r);
		chk(16'(lpd_panel_model_inst.bias_flips - base), 16'(f));
		chk(16'(lpd_panel_model_inst.bad_bias), 16'h0000);
	endtask : t_ratio

	task automatic t_data;
		for (int k = 0; k < lpd_panel_model_inst.nib_total && k < 4096; k++) begin
			chk(16'(lpd_panel_model_inst.got[k]), 16'(pat(k)));
		end
		chk(16'(lpd_panel_model_inst.bad_idle), 16'h0000);
	endtask : t_data

	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_idle();
		t_frames();
		t_save(4);
		t_ratio(2'h1, 8, 8'h02, 4);
		t_ratio(2'h2, 16, 8'h02, 4);
		t_ratio(2'h3, 16, 8'h00, 1);
		t_data();
		complete_run();
	end
endmodule : lpd_timing_bench
